// file: design/trace_readout_pkg.sv
// Package: register map, fields, reset values and encodings for trace readout
package trace_readout_pkg;
  // Printed offsets are not all multiples of four: indices, byte address = 4 * index
  localparam logic [7:0] IDX_TRACE_WINDOW = 8'h24;
  localparam logic [7:0] IDX_VALID_LINE_COUNT = 8'h26;
  localparam logic [7:0] IDX_STATE_CONTROL = 8'h27;
  // Own registers
  localparam logic [7:0] IDX_DEBUG_CONTROL_ONE = 8'h28;
  localparam logic [7:0] IDX_TRACE_CONTROL = 8'h29;
  localparam logic [7:0] IDX_DEBUG_STATUS = 8'h2A;
  localparam logic [7:0] IDX_WINDOW_ACCESS = 8'h2B;
  localparam logic [7:0] IDX_TRACE_STORE = 8'h2C;
  localparam logic [7:0] IDX_TRACE_STORE_HIGH = 8'h2D;

  // debug_control_one fields
  localparam int ARM_BIT = 7;
  localparam int SELECT_LSB = 0;
  // trace control fields
  localparam int SOURCE_BIT = 6;
  localparam int ALIGN_LSB = 0;
  // debug_status fields
  localparam int FULL_BIT = 7;
  // window access mode: bit 0 byte access, bit 1 misaligned
  localparam int ACCESS_BYTE_BIT = 0;
  localparam int ACCESS_MISALIGN_BIT = 1;

  localparam int LINE_W = 64;
  localparam int PORTION_W = 16;
  localparam int LINES = 64;
  localparam int LINE_IDX_W = 6;
  localparam int PORTION_IDX_W = 2;
  localparam int COUNT_W = 7;
  localparam int SC_W = 4;

  localparam logic [1:0] SELECT_STATE1 = 2'h0;
  localparam logic [1:0] SELECT_STATE2 = 2'h1;
  localparam logic [1:0] SELECT_STATE3 = 2'h2;
  localparam logic [1:0] SELECT_MATCH = 2'h3;

  localparam logic [1:0] ALIGN_END = 2'h0;
  localparam logic [1:0] ALIGN_BEGIN = 2'h1;
  localparam logic [1:0] ALIGN_MID = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h00;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 7'h01;
endpackage

// file: design/trace_store.sv
// Trace line storage: flip-flop array with write port and portion read
`timescale 1ns/100ps
module trace_store (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [trace_readout_pkg::LINE_IDX_W-1:0] wr_line,
  input wire logic [trace_readout_pkg::LINE_W-1:0] wr_data,
  input wire logic [trace_readout_pkg::LINE_IDX_W-1:0] rd_line,
  input wire logic [trace_readout_pkg::PORTION_IDX_W-1:0] rd_portion,
  output logic [trace_readout_pkg::PORTION_W-1:0] rd_data
);
  typedef struct packed {
    logic [trace_readout_pkg::LINES-1:0][trace_readout_pkg::LINE_W-1:0] mem;
  } store_state_t;

  store_state_t s_q;
  store_state_t s_d;

  // Contents have no reset: undefined at power-on, kept over other resets
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_line] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // Portion 0 is the low 16 bits of the line
  assign rd_data = s_q.mem[rd_line][rd_portion*trace_readout_pkg::PORTION_W +: 16];
endmodule // trace_store

// file: design/trace_buffer_readout.sv
// Trace buffer readout: AXI4-Lite register window, count, full flag, select
`timescale 1ns/100ps
module trace_buffer_readout (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire logic secured,
  input wire logic half_line_stored,
  input wire logic [3:0] match_flags,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic armed,
  output logic trace_source_enable,
  output logic [1:0] trigger_alignment,
  output logic [1:0] comparator_register_select
);
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_idx;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic arm;
    logic unlocked;
    logic source_en;
    logic [1:0] align;
    logic [1:0] select;
    logic [1:0] access_mode;
    logic [trace_readout_pkg::COUNT_W-1:0] count;
    logic full;
    logic [trace_readout_pkg::SC_W-1:0] sc1;
    logic [trace_readout_pkg::SC_W-1:0] sc2;
    logic [trace_readout_pkg::SC_W-1:0] sc3;
    logic [trace_readout_pkg::LINE_IDX_W-1:0] rd_line;
    logic [trace_readout_pkg::PORTION_IDX_W-1:0] rd_portion;
    logic [trace_readout_pkg::LINE_IDX_W-1:0] wr_line;
    logic [31:0] stage_low;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic store_wr;
  logic [trace_readout_pkg::LINE_W-1:0] store_data;
  logic [trace_readout_pkg::PORTION_W-1:0] portion;

  // Word index of a byte address; higher address bits must be zero
  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic in_range(input logic [31:0] addr);
    in_range = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
  endfunction

  // Trace line storage
  trace_store u_store (
    .clk(clk),
    .wr_en(store_wr),
    .wr_line(s_q.wr_line),
    .wr_data(store_data),
    .rd_line(s_q.rd_line),
    .rd_portion(s_q.rd_portion),
    .rd_data(portion)
  );

  // Bus slave, arm/lock, count and pointer logic
  always_comb begin
    logic do_wr;
    logic do_rd;
    logic rd_ok;
    logic [7:0] ridx;
    logic [31:0] val;
    logic [1:0] resp;
    do_wr = 1'b0;
    do_rd = 1'b0;
    rd_ok = 1'b0;
    ridx = word_index(s_axi_araddr);
    val = 32'h00000000;
    resp = trace_readout_pkg::RESP_OKAY;
    s_d = s_q;
    store_wr = 1'b0;
    store_data = {s_q.w_data, s_q.stage_low};

    // Address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = in_range(s_axi_awaddr) || 1'b1;
      s_d.aw_idx = in_range(s_axi_awaddr) ? word_index(s_axi_awaddr) : 8'hFF;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid_q_free()) begin
      do_wr = s_q.aw_held && s_q.w_held;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Capture side: each half line stored while armed increments the count
    if (half_line_stored && s_q.arm) begin
      s_d.count = s_q.count + trace_readout_pkg::COUNT_STEP;
      if (s_d.count == trace_readout_pkg::COUNT_RESET) begin
        s_d.full = 1'b1;
        if (s_q.align == trace_readout_pkg::ALIGN_BEGIN) begin
          s_d.arm = 1'b0;
          s_d.count = trace_readout_pkg::COUNT_RESET;
        end
      end
    end

    // Register writes
    if (do_wr) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = trace_readout_pkg::RESP_OKAY;
      case (s_q.aw_idx)
        trace_readout_pkg::IDX_TRACE_WINDOW: begin
          // Write with byte lanes 0 and 1 both strobed while disarmed: unlock only
          if (!s_q.arm && s_q.w_strb[1:0] == 2'h3) begin
            s_d.unlocked = 1'b1;
          end
        end
        trace_readout_pkg::IDX_VALID_LINE_COUNT: begin
          s_d.count = s_d.count;
        end
        trace_readout_pkg::IDX_STATE_CONTROL: begin
          if (!s_q.arm) begin
            case (s_q.select)
              trace_readout_pkg::SELECT_STATE1: s_d.sc1 = s_q.w_data[3:0];
              trace_readout_pkg::SELECT_STATE2: s_d.sc2 = s_q.w_data[3:0];
              trace_readout_pkg::SELECT_STATE3: s_d.sc3 = s_q.w_data[3:0];
              default: s_d.sc1 = s_q.sc1;
            endcase
          end
        end
        trace_readout_pkg::IDX_DEBUG_CONTROL_ONE: begin
          s_d.select = s_q.w_data[trace_readout_pkg::SELECT_LSB +: 2];
          s_d.arm = s_q.w_data[trace_readout_pkg::ARM_BIT];
          if (s_q.w_data[trace_readout_pkg::ARM_BIT]) begin
            s_d.unlocked = 1'b0;
            s_d.count = trace_readout_pkg::COUNT_RESET;
            s_d.full = 1'b0;
            s_d.rd_line = '0;
            s_d.rd_portion = '0;
            s_d.wr_line = '0;
          end
        end
        trace_readout_pkg::IDX_TRACE_CONTROL: begin
          if (!s_q.arm) begin
            s_d.source_en = s_q.w_data[trace_readout_pkg::SOURCE_BIT] && !secured;
            s_d.align = s_q.w_data[trace_readout_pkg::ALIGN_LSB +: 2];
          end
        end
        trace_readout_pkg::IDX_WINDOW_ACCESS: s_d.access_mode = s_q.w_data[1:0];
        trace_readout_pkg::IDX_TRACE_STORE: s_d.stage_low = s_q.w_data;
        trace_readout_pkg::IDX_TRACE_STORE_HIGH: begin
          store_wr = 1'b1;
          s_d.wr_line = s_q.wr_line + 6'h01;
        end
        default: s_d.bresp = trace_readout_pkg::RESP_SLVERR;
      endcase
    end

    // Register reads
    if (s_axi_arvalid && !s_q.rvalid) begin
      do_rd = 1'b1;
      if (!in_range(s_axi_araddr)) begin
        resp = trace_readout_pkg::RESP_SLVERR;
      end else begin
        case (ridx)
          trace_readout_pkg::IDX_TRACE_WINDOW: begin
            rd_ok = s_q.unlocked && !secured && !s_q.arm && s_q.source_en
              && (s_q.access_mode == 2'h0);
            val = rd_ok ? {16'h0000, portion} : 32'h00000000;
          end
          trace_readout_pkg::IDX_VALID_LINE_COUNT: val = {25'h0000000, s_q.count};
          trace_readout_pkg::IDX_STATE_CONTROL: begin
            case (s_q.select)
              trace_readout_pkg::SELECT_STATE1: val = {28'h0000000, s_q.sc1};
              trace_readout_pkg::SELECT_STATE2: val = {28'h0000000, s_q.sc2};
              trace_readout_pkg::SELECT_STATE3: val = {28'h0000000, s_q.sc3};
              default: val = {28'h0000000, match_flags};
            endcase
          end
          trace_readout_pkg::IDX_DEBUG_CONTROL_ONE:
            val = {24'h000000, s_q.arm, 5'h00, s_q.select};
          trace_readout_pkg::IDX_TRACE_CONTROL:
            val = {24'h000000, 1'b0, s_q.source_en, 4'h0, s_q.align};
          trace_readout_pkg::IDX_DEBUG_STATUS:
            val = {24'h000000, s_q.full, 6'h00, s_q.unlocked};
          trace_readout_pkg::IDX_WINDOW_ACCESS: val = {30'h00000000, s_q.access_mode};
          default: resp = trace_readout_pkg::RESP_SLVERR;
        endcase
      end
      s_d.rvalid = 1'b1;
      s_d.rdata = val;
      s_d.rresp = resp;
      // Pointer advance only on a valid trace read; count untouched
      if (rd_ok) begin
        s_d.rd_portion = s_q.rd_portion + 2'h1;
        if (s_q.rd_portion == 2'h3) begin
          s_d.rd_line = s_q.rd_line + 6'h01;
        end
      end
    end

    // Synchronous resets; power-on clears count and full, others keep them
    if (reset || power_on_reset) begin
      s_d.aw_held = 1'b0;
      s_d.aw_idx = 8'h00;
      s_d.w_held = 1'b0;
      s_d.w_data = 32'h00000000;
      s_d.w_strb = 4'h0;
      s_d.bvalid = 1'b0;
      s_d.bresp = trace_readout_pkg::RESP_OKAY;
      s_d.rvalid = 1'b0;
      s_d.rdata = 32'h00000000;
      s_d.rresp = trace_readout_pkg::RESP_OKAY;
      s_d.arm = 1'b0;
      s_d.unlocked = 1'b0;
      s_d.source_en = 1'b0;
      s_d.align = trace_readout_pkg::ALIGN_END;
      s_d.select = trace_readout_pkg::SELECT_STATE1;
      s_d.access_mode = 2'h0;
      s_d.sc1 = 4'h0;
      s_d.sc2 = 4'h0;
      s_d.sc3 = 4'h0;
      s_d.rd_line = '0;
      s_d.rd_portion = '0;
      s_d.stage_low = 32'h00000000;
      store_wr = 1'b0;
    end
    if (power_on_reset) begin
      s_d.count = trace_readout_pkg::COUNT_RESET;
      s_d.full = 1'b0;
      s_d.wr_line = '0;
    end
  end

  // Write response slot free
  function automatic logic s_axi_bvalid_q_free();
    s_axi_bvalid_q_free = !s_q.bvalid;
  endfunction

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // Outputs straight from state
  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready = !s_q.w_held;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign armed = s_q.arm;
  assign trace_source_enable = s_q.source_en;
  assign trigger_alignment = s_q.align;
  assign comparator_register_select = s_q.select;
endmodule // trace_buffer_readout

// file: tb/trace_buffer_readout_asserts.sv
// Checker: port-level properties of the trace buffer readout
`timescale 1ns/100ps
module trace_buffer_readout_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_on_reset,
  input wire logic secured,
  input wire logic [3:0] match_flags,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic armed,
  input wire logic trace_source_enable,
  input wire logic [1:0] trigger_alignment,
  input wire logic [1:0] comparator_register_select
);
  // Byte addresses, four times the index
  localparam logic [31:0] TW = 32'h00000090;
  localparam logic [31:0] CNT = 32'h00000098;
  localparam logic [31:0] SC = 32'h0000009C;
  default clocking @(posedge clk); endclocking
  default disable iff (reset || power_on_reset);
  // Read address taken at one register
  sequence s_rd(logic [31:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  // Answers to reads, judged the cycle after the address is taken
  property p_armed_zero; s_rd(TW) ##0 armed |=> s_axi_rdata == 32'h0; endproperty
  property p_secured_zero; s_rd(TW) ##0 secured |=> s_axi_rdata == 32'h0; endproperty
  property p_source_zero; s_rd(TW) ##0 !trace_source_enable |=> s_axi_rdata == 32'h0; endproperty
  property p_match_view;
    s_rd(SC) ##0 comparator_register_select == trace_readout_pkg::SELECT_MATCH
      |=> s_axi_rdata[3:0] == $past(match_flags);
  endproperty
  property p_count_field; s_rd(CNT) |=> s_axi_rdata[31:7] == 25'h0; endproperty
  property p_count_ok; s_rd(CNT) |=> s_axi_rresp == trace_readout_pkg::RESP_OKAY; endproperty
  // Control levels
  property p_secure_source; secured && !trace_source_enable |=> !trace_source_enable; endproperty
  property p_align_hold; armed |=> $stable(trigger_alignment); endproperty
  a_armed_zero: assert property (p_armed_zero)
    else $error("trace read while armed returned data");
  a_secured_zero: assert property (p_secured_zero)
    else $error("trace read while secured returned data");
  a_source_zero: assert property (p_source_zero)
    else $error("trace read without source enable returned data");
  a_match_view: assert property (p_match_view)
    else $error("match flags not shown at shared address");
  a_count_field: assert property (p_count_field)
    else $error("count read has bits above the count field");
  a_count_ok: assert property (p_count_ok)
    else $error("count read refused");
  a_secure_source: assert property (p_secure_source)
    else $error("source enable set while secured");
  a_align_hold: assert property (p_align_hold)
    else $error("alignment changed while armed");
endmodule // trace_buffer_readout_asserts

bind trace_buffer_readout trace_buffer_readout_asserts trace_buffer_readout_asserts_i (
  .clk, .reset, .power_on_reset, .secured, .match_flags, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .armed, .trace_source_enable,
  .trigger_alignment, .comparator_register_select
);

// file: tb/axi_host.sv
// Host model: AXI4-Lite master with one write and one read task
`timescale 1ns/100ps
module axi_host (
  input wire logic clk,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} <= 100'h0;
  end
  // Address and data offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // One idle edge so the next call never re-raises in the same step
    @(posedge clk);
  endtask
  // Data and response taken at the edge rvalid is seen
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
endmodule // axi_host

// file: tb/tb.sv
// Testbench: register-level scenarios for the trace buffer readout
`timescale 1ns/100ps
module tb;
  localparam int LIMIT = 30000;
  // Byte addresses, four times the index
  localparam logic [31:0] TW = 32'h90, CNT = 32'h98, SC = 32'h9C, DC1 = 32'hA0, TC = 32'hA4;
  localparam logic [31:0] ST = 32'hA8, AM = 32'hAC, SL = 32'hB0, SH = 32'hB4;
  logic clk = 1'b0;
  logic reset, power_on_reset, secured, half_line_stored, armed, trace_source_enable;
  logic [3:0] match_flags, s_axi_wstrb;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, trigger_alignment, comparator_register_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] nxt;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  trace_buffer_readout trace_buffer_readout_i (.*);
  axi_host axi_host_i (.*);
  always #4 clk = ~clk;
  // Compare and count
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic w(input logic [31:0] a, input logic [31:0] v);
    axi_host_i.wr(a, v, 4'hF);
  endtask
  task automatic rc(input string n, input logic [31:0] a, input logic [31:0] exp);
    axi_host_i.rd(a, d, r);
    chk(n, d, exp);
  endtask
  task automatic full(input logic exp);
    axi_host_i.rd(ST, d, r);
    chk("full", {31'h0, d[7]}, {31'h0, exp});
  endtask
  // Trace window read: zero when blocked, else the next portion
  task automatic tw(input logic z);
    if (z) rc("window", TW, 32'h0);
    else begin
      rc("window", TW, {16'h0, 8'h3C, nxt});
      nxt++;
    end
  endtask
  // Find where the read pointer stands
  task automatic sync;
    axi_host_i.rd(TW, d, r);
    chk("pattern", {24'h0, d[15:8]}, 32'h3C);
    nxt = d[7:0] + 8'h01;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      half_line_stored <= 1'b1;
      @(posedge clk);
      half_line_stored <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rst(input logic por);
    reset <= 1'b1;
    power_on_reset <= por;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    power_on_reset <= 1'b0;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    secured <= 1'b0;
    half_line_stored <= 1'b0;
    match_flags <= 4'hB;
    rst(1'b1);
    // Fill every line with a counting pattern
    for (int k = 0; k < 64; k++) begin
      w(SL, {8'h3C, 8'(4 * k + 1), 8'h3C, 8'(4 * k)});
      w(SH, {8'h3C, 8'(4 * k + 3), 8'h3C, 8'(4 * k + 2)});
    end
    rc("count", CNT, 32'h0);
    w(TC, 32'h40);
    axi_host_i.wr(TW, 32'h0, 4'h3);
    sync();
    for (int i = 0; i < 256; i++) tw(1'b0);
    // Byte and misaligned modes
    for (int m = 1; m < 4; m++) begin
      w(AM, 32'(m));
      tw(1'b1);
    end
    w(AM, 32'h0);
    tw(1'b0);
    // Secured chip and cleared source
    secured <= 1'b1;
    tw(1'b1);
    w(TC, 32'h0);
    w(TC, 32'h40);
    chk("source", {31'h0, trace_source_enable}, 32'h0);
    secured <= 1'b0;
    tw(1'b1);
    w(TC, 32'h40);
    tw(1'b0);
    // Shared state control address
    for (int s = 0; s < 3; s++) begin
      w(DC1, 32'(s));
      w(SC, 32'(s + 5));
    end
    for (int s = 0; s < 4; s++) begin
      w(DC1, 32'(s));
      chk("select", {30'h0, comparator_register_select}, 32'(s));
      axi_host_i.rd(SC, d, r);
      chk("state", {28'h0, d[3:0]}, (s == 3) ? 32'hB : 32'(s + 5));
    end
    // End alignment session past the wrap
    w(DC1, 32'h80);
    chk("armed", {31'h0, armed}, 32'h1);
    tw(1'b1);
    axi_host_i.wr(TW, 32'h0, 4'h3);
    pulse(5);
    rc("count", CNT, 32'h5);
    w(CNT, 32'h7F);
    rc("count", CNT, 32'h5);
    pulse(123);
    rc("count", CNT, 32'h0);
    full(1'b1);
    pulse(2);
    rc("count", CNT, 32'h2);
    chk("armed", {31'h0, armed}, 32'h1);
    rst(1'b0);
    rc("count", CNT, 32'h2);
    full(1'b1);
    // System reset cleared the source enable; set it again before reading
    w(TC, 32'h40);
    axi_host_i.wr(TW, 32'h0, 4'h1);
    tw(1'b1);
    axi_host_i.wr(TW, 32'h0, 4'h3);
    sync();
    tw(1'b0);
    rc("count", CNT, 32'h2);
    // Begin alignment stops at the wrap
    w(TC, 32'h41);
    chk("align", {30'h0, trigger_alignment}, 32'h1);
    w(DC1, 32'h80);
    rc("count", CNT, 32'h0);
    full(1'b0);
    pulse(128);
    chk("armed", {31'h0, armed}, 32'h0);
    rc("count", CNT, 32'h0);
    full(1'b1);
    // Mid alignment keeps counting
    w(TC, 32'h42);
    w(DC1, 32'h80);
    pulse(130);
    rc("count", CNT, 32'h2);
    rst(1'b1);
    rc("count", CNT, 32'h0);
    full(1'b0);
    axi_host_i.rd(32'h0, d, r);
    chk("resp", {30'h0, r}, {30'h0, trace_readout_pkg::RESP_SLVERR});
    conclude();
  end
endmodule // tb
